// *** lpcr_pkg.sv ***
// Purpose: shared constants and types for the LED and PHY control register pair
// Assumes: 10 MHz core clock, classic Wishbone with 32-bit data
// Notes: register indices are word indices, byte address is four times the index
`default_nettype none

package lpcr_pkg;

  // clock and blink timebase
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned BLINK_MS_0 = 50;
  localparam int unsigned BLINK_MS_1 = 100;
  localparam int unsigned BLINK_MS_2 = 200;
  localparam int unsigned BLINK_MS_3 = 500;
  localparam int unsigned BLINK_CYC_0 = BLINK_MS_0 * (CLK_HZ / 1000);
  localparam int unsigned BLINK_CYC_1 = BLINK_MS_1 * (CLK_HZ / 1000);
  localparam int unsigned BLINK_CYC_2 = BLINK_MS_2 * (CLK_HZ / 1000);
  localparam int unsigned BLINK_CYC_3 = BLINK_MS_3 * (CLK_HZ / 1000);
  localparam int unsigned BLINK_CNT_W = 23;

  // register map
  localparam logic [7:0] LED_CONTROL_IDX = 8'h18;
  localparam logic [7:0] PHY_CONTROL_STATUS_IDX = 8'h19;
  localparam logic [7:0] LED_CONTROL_ADR = 8'h60;
  localparam logic [7:0] PHY_CONTROL_STATUS_ADR = 8'h64;

  // led_control fields
  localparam int unsigned LED_RATE_HI = 10;
  localparam int unsigned LED_RATE_LO = 9;
  localparam int unsigned LED_POL_BIT = 7;
  localparam int unsigned LED_DRIVE_BIT = 4;
  localparam int unsigned LED_FORCE_VAL_BIT = 1;
  localparam logic [15:0] LED_WR_MASK = 16'h07FF;
  localparam logic [1:0] LED_RATE_RESET = 2'h2;
  localparam logic [15:0] LED_RESET = 16'h0400;

  // phy_control_status fields
  localparam int unsigned PHY_AMDIX_BIT = 15;
  localparam int unsigned PHY_CROSS_BIT = 14;
  localparam int unsigned PHY_PAUSE_RX_BIT = 13;
  localparam int unsigned PHY_PAUSE_TX_BIT = 12;
  localparam int unsigned PHY_LINK_BIT = 11;
  localparam int unsigned PHY_BYPASS_BIT = 7;
  localparam logic [15:0] PHY_WR_MASK = 16'hC0E0;
  localparam logic [15:0] PHY_RESET = 16'h8000;

  // strap capture: two synchroniser stages, then one capture edge
  localparam logic [1:0] STRAP_CAPTURE_CNT = 2'h2;

  // straps sampled at reset
  typedef struct packed {
    logic common_pin_mode;
    logic led_pol;
    logic auto_crossover;
    logic force_crossover;
    logic [4:0] phy_addr;
  } lpcr_strap_t;

  // advertisement bits 11:10 (asymmetric pause, pause)
  typedef struct packed {
    logic asym_pause;
    logic pause;
  } lpcr_pause_adv_t;

  typedef struct packed {
    lpcr_strap_t strap_s1;
    lpcr_strap_t strap_s2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [15:0] led;
    logic [15:0] phy;
    logic [4:0] phy_addr;
    logic pause_rx;
    logic pause_tx;
    logic link_stat;
    logic [BLINK_CNT_W-1:0] blink_cnt;
    logic blink_phase;
    logic [1:0] rate_prev;
    logic led_pin;
    logic amdix_out;
    logic cross_out;
    logic ack;
    logic [31:0] dat;
  } lpcr_state_t;

endpackage

`default_nettype wire

// *** lpcr_regs.sv ***
// Purpose: led_control and phy_control_status registers with link LED drive
// Assumes: straps are steady around reset; link, pause and activity inputs are on REF_CLK_I
// Notes: answers every Wishbone access one cycle after it is seen
//
// How it works
// - blink rate field picks 50, 100, 200 or 500 ms; resets to 2
// - LED polarity is active low in common mode, strapped level otherwise
// - software write to polarity bit overrides strap: 0 low, 1 high active
// - drive select set forces LED pin to the forced value, else normal
// - forced value bit: 0 drives pin low, 1 drives pin high
// - auto crossover enable resets on in common mode, strapped otherwise; writable
// - forced crossover bit 0 keeps pairs straight, 1 swaps them
// - enhanced mode with auto crossover strap off: forced crossover from strap
// - pause receive status resolved from local and partner advert bits 11:10
// - pause transmit status resolved from the same advertisement bits
// - pause bits follow the pause table, only for full duplex resolution
// - link status reads 1 only during autonegotiated 100 Mbps full duplex link
// - bypass bit removes LED stretching, LED follows raw activity
// - PHY address field is read-only, latched from straps at reset
`timescale 1ns/1ps
`default_nettype none

module lpcr_regs #(
  parameter int unsigned BLINK_CYC_50MS = lpcr_pkg::BLINK_CYC_0,
  parameter int unsigned BLINK_CYC_100MS = lpcr_pkg::BLINK_CYC_1,
  parameter int unsigned BLINK_CYC_200MS = lpcr_pkg::BLINK_CYC_2,
  parameter int unsigned BLINK_CYC_500MS = lpcr_pkg::BLINK_CYC_3
) (
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire lpcr_pkg::lpcr_strap_t STRAPS_I,
  input wire lpcr_pkg::lpcr_pause_adv_t LOCAL_ADVERT_I,
  input wire lpcr_pkg::lpcr_pause_adv_t PARTNER_ABILITY_I,
  input wire logic HCD_FULL_DUPLEX_I,
  input wire logic LINK_100FD_AN_I,
  input wire logic LINK_UP_I,
  input wire logic ACTIVITY_RAW_I,
  input wire logic ACTIVITY_STRETCHED_I,
  output logic LINK_LED_PIN_O,
  output logic AUTO_CROSSOVER_EN_O,
  output logic PAIR_CROSSOVER_O
);
  import lpcr_pkg::*;

  lpcr_state_t s_q;
  lpcr_state_t s_d;

  logic bus_req;
  logic wr_led;
  logic wr_phy;
  logic [15:0] lane_mask;
  logic [15:0] rd_led;
  logic [15:0] rd_phy;
  logic [BLINK_CNT_W-1:0] blink_last;
  logic act_src;
  logic led_on;

  function automatic logic [BLINK_CNT_W-1:0] rate_last(input logic [1:0] rate);
    logic [BLINK_CNT_W-1:0] v;
    v = BLINK_CNT_W'(BLINK_CYC_200MS - 1);
    case (rate)
      2'h0: v = BLINK_CNT_W'(BLINK_CYC_50MS - 1);
      2'h1: v = BLINK_CNT_W'(BLINK_CYC_100MS - 1);
      2'h2: v = BLINK_CNT_W'(BLINK_CYC_200MS - 1);
      default: v = BLINK_CNT_W'(BLINK_CYC_500MS - 1);
    endcase
    return v;
  endfunction

  assign bus_req = WB_CYC_I & WB_STB_I & ~s_q.ack;
  assign lane_mask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign blink_last = rate_last(s_q.led[LED_RATE_HI:LED_RATE_LO]);
  assign act_src = s_q.phy[PHY_BYPASS_BIT] ? ACTIVITY_RAW_I : ACTIVITY_STRETCHED_I;
  assign led_on = LINK_UP_I & ~(act_src & s_q.blink_phase);

  always_comb begin
    rd_led = s_q.led & LED_WR_MASK;
    rd_phy = s_q.phy & PHY_WR_MASK;
    rd_phy[PHY_PAUSE_RX_BIT] = s_q.pause_rx;
    rd_phy[PHY_PAUSE_TX_BIT] = s_q.pause_tx;
    rd_phy[PHY_LINK_BIT] = s_q.link_stat;
    rd_phy[4:0] = s_q.phy_addr;
  end

  always_comb begin
    s_d = s_q;
    wr_led = 1'b0;
    wr_phy = 1'b0;

    // strap synchroniser and one-time capture after reset release
    s_d.strap_s1 = STRAPS_I;
    s_d.strap_s2 = s_q.strap_s1;
    if (!s_q.strap_done) begin
      if (s_q.strap_cnt == STRAP_CAPTURE_CNT) begin
        s_d.strap_done = 1'b1;
        s_d.phy_addr = s_q.strap_s2.phy_addr;
        if (s_q.strap_s2.common_pin_mode) begin
          s_d.led[LED_POL_BIT] = 1'b0;
          s_d.phy[PHY_AMDIX_BIT] = 1'b1;
          s_d.phy[PHY_CROSS_BIT] = 1'b0;
        end else begin
          s_d.led[LED_POL_BIT] = s_q.strap_s2.led_pol;
          s_d.phy[PHY_AMDIX_BIT] = s_q.strap_s2.auto_crossover;
          s_d.phy[PHY_CROSS_BIT] = ~s_q.strap_s2.auto_crossover
                                   & s_q.strap_s2.force_crossover;
        end
      end else begin
        s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      end
    end

    // wishbone slave: one-cycle registered answer
    s_d.ack = bus_req;
    s_d.dat = 32'h0000_0000;
    if (bus_req) begin
      if (WB_ADR_I == LED_CONTROL_ADR) begin
        s_d.dat = {16'h0000, rd_led};
        wr_led = WB_WE_I;
      end else if (WB_ADR_I == PHY_CONTROL_STATUS_ADR) begin
        s_d.dat = {16'h0000, rd_phy};
        wr_phy = WB_WE_I;
      end else begin
        s_d.dat = 32'h0000_0000;
      end
    end
    if (wr_led) begin
      s_d.led = (s_d.led & ~(lane_mask & LED_WR_MASK))
                | (WB_DAT_I[15:0] & lane_mask & LED_WR_MASK);
    end
    if (wr_phy) begin
      s_d.phy = (s_d.phy & ~(lane_mask & PHY_WR_MASK))
                | (WB_DAT_I[15:0] & lane_mask & PHY_WR_MASK);
    end
    if (!WB_CYC_I || !WB_STB_I) begin
      s_d.dat = 32'h0000_0000;
    end

    // pause resolution and link status
    s_d.pause_rx = 1'b0;
    s_d.pause_tx = 1'b0;
    if (HCD_FULL_DUPLEX_I) begin
      if (LOCAL_ADVERT_I.pause && PARTNER_ABILITY_I.pause) begin
        s_d.pause_rx = 1'b1;
        s_d.pause_tx = 1'b1;
      end else if (LOCAL_ADVERT_I.pause && LOCAL_ADVERT_I.asym_pause
                   && PARTNER_ABILITY_I.asym_pause) begin
        s_d.pause_rx = 1'b1;
      end else if (LOCAL_ADVERT_I.asym_pause && PARTNER_ABILITY_I.pause
                   && PARTNER_ABILITY_I.asym_pause) begin
        s_d.pause_tx = 1'b1;
      end
    end
    s_d.link_stat = LINK_100FD_AN_I;

    // blink timebase
    s_d.rate_prev = s_q.led[LED_RATE_HI:LED_RATE_LO];
    if (s_q.rate_prev != s_q.led[LED_RATE_HI:LED_RATE_LO]) begin
      s_d.blink_cnt = '0;
      s_d.blink_phase = 1'b0;
    end else if (s_q.blink_cnt >= blink_last) begin
      s_d.blink_cnt = '0;
      s_d.blink_phase = ~s_q.blink_phase;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + BLINK_CNT_W'(1);
    end

    // pin drive
    if (s_q.led[LED_DRIVE_BIT]) begin
      s_d.led_pin = s_q.led[LED_FORCE_VAL_BIT];
    end else begin
      s_d.led_pin = s_q.led[LED_POL_BIT] ? led_on : ~led_on;
    end
    s_d.amdix_out = s_q.phy[PHY_AMDIX_BIT];
    s_d.cross_out = s_q.phy[PHY_CROSS_BIT];
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_q <= '0;
      s_q.led <= LED_RESET;
      s_q.phy <= PHY_RESET;
      s_q.rate_prev <= LED_RATE_RESET;
      s_q.led_pin <= 1'b1;
      s_q.amdix_out <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign WB_DAT_O = s_q.dat;
  assign WB_ACK_O = s_q.ack;
  assign LINK_LED_PIN_O = s_q.led_pin;
  assign AUTO_CROSSOVER_EN_O = s_q.amdix_out;
  assign PAIR_CROSSOVER_O = s_q.cross_out;

  // checks
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  a_ack_single_pulse: assert property (s_q.ack |=> !s_q.ack)
    else $error("ack held longer than one cycle");

  a_rate_reset_two: assert property (!s_q.strap_done && s_q.strap_cnt == 2'h0 |->
      s_q.led[LED_RATE_HI:LED_RATE_LO] == 2'h2)
    else $error("blink rate not two after reset");

  a_pol_common_mode: assert property (!s_q.strap_done && s_q.strap_cnt == 2'h2
      && s_q.strap_s2.common_pin_mode && !bus_req |=> !s_q.led[LED_POL_BIT])
    else $error("polarity not active low in common mode");

  a_pol_sw_write: assert property (wr_led && WB_SEL_I[0] |=>
      s_q.led[LED_POL_BIT] == $past(WB_DAT_I[7]))
    else $error("polarity write not taken");

  a_forced_pin_level: assert property (s_q.led[LED_DRIVE_BIT] ##1 s_q.led[LED_DRIVE_BIT]
      |-> LINK_LED_PIN_O == $past(s_q.led[LED_FORCE_VAL_BIT]))
    else $error("forced LED level not driven");

  a_forced_high: assert property (s_q.led[LED_DRIVE_BIT] && s_q.led[LED_FORCE_VAL_BIT]
      |=> LINK_LED_PIN_O)
    else $error("forced high value not on pin");

  a_amdix_capture: assert property (!s_q.strap_done && s_q.strap_cnt == 2'h2 && !bus_req
      |=> s_q.phy[PHY_AMDIX_BIT] == ($past(s_q.strap_s2.common_pin_mode)
          | $past(s_q.strap_s2.auto_crossover)))
    else $error("auto crossover reset value wrong");

  a_cross_output: assert property (##1 PAIR_CROSSOVER_O == $past(s_q.phy[PHY_CROSS_BIT]))
    else $error("pair crossover output does not follow bit");

  a_cross_strap: assert property (!s_q.strap_done && s_q.strap_cnt == 2'h2 && !bus_req
      && !s_q.strap_s2.common_pin_mode && !s_q.strap_s2.auto_crossover
      |=> s_q.phy[PHY_CROSS_BIT] == $past(s_q.strap_s2.force_crossover))
    else $error("forced crossover strap not latched");

  a_pause_symmetric: assert property (HCD_FULL_DUPLEX_I && LOCAL_ADVERT_I.pause
      && PARTNER_ABILITY_I.pause |=> s_q.pause_rx && s_q.pause_tx)
    else $error("symmetric pause not resolved");

  a_pause_tx_only: assert property (HCD_FULL_DUPLEX_I && !LOCAL_ADVERT_I.pause
      && LOCAL_ADVERT_I.asym_pause && PARTNER_ABILITY_I == 2'h3
      |=> s_q.pause_tx && !s_q.pause_rx)
    else $error("transmit-only pause not resolved");

  a_pause_half_duplex: assert property (!HCD_FULL_DUPLEX_I |=>
      !s_q.pause_rx && !s_q.pause_tx)
    else $error("pause set without full duplex");

  a_link_status: assert property (##1 s_q.link_stat == $past(LINK_100FD_AN_I))
    else $error("link status does not follow link input");

  a_bypass_raw: assert property (!s_q.led[LED_DRIVE_BIT] && s_q.phy[PHY_BYPASS_BIT]
      && s_q.led[LED_POL_BIT] |=> LINK_LED_PIN_O == ($past(LINK_UP_I)
          & ~($past(ACTIVITY_RAW_I) & $past(s_q.blink_phase))))
    else $error("bypass does not use raw activity");

  a_addr_stable: assert property (s_q.strap_done |=> $stable(s_q.phy_addr))
    else $error("PHY address changed after capture");

  a_blink_reload: assert property ($changed(s_q.led[LED_RATE_HI:LED_RATE_LO])
      |=> s_q.blink_cnt == '0 && !s_q.blink_phase)
    else $error("blink counter not reloaded on rate change");

  a_ack_follows_req: assert property (bus_req |=> s_q.ack)
    else $error("request not acknowledged next cycle");

  a_dat_idle_zero: assert property (!s_q.ack |-> s_q.dat == 32'h0000_0000)
    else $error("read data not zero outside ack");

  a_dat_upper_zero: assert property (s_q.dat[31:16] == 16'h0000)
    else $error("upper read data not zero");

  a_unmapped_ignored: assert property (bus_req && s_q.strap_done
      && WB_ADR_I != LED_CONTROL_ADR && WB_ADR_I != PHY_CONTROL_STATUS_ADR
      |=> $stable(s_q.led) && $stable(s_q.phy))
    else $error("unmapped access changed a register");

  a_rate_write: assert property (wr_led && WB_SEL_I[1] |=>
      s_q.led[LED_RATE_HI:LED_RATE_LO] == $past(WB_DAT_I[10:9]))
    else $error("blink rate write not taken");

  a_blink_bounded: assert property (s_q.rate_prev == s_q.led[LED_RATE_HI:LED_RATE_LO]
      |-> s_q.blink_cnt <= blink_last)
    else $error("blink counter beyond its rate limit");

  a_active_low_pin: assert property (!s_q.led[LED_DRIVE_BIT] && !s_q.led[LED_POL_BIT]
      |=> LINK_LED_PIN_O == !$past(led_on))
    else $error("active low link LED not inverted");

  a_drive_write: assert property (wr_led && WB_SEL_I[0] |=>
      s_q.led[LED_DRIVE_BIT] == $past(WB_DAT_I[4]))
    else $error("drive select write not taken");

  a_forced_low: assert property (s_q.led[LED_DRIVE_BIT] && !s_q.led[LED_FORCE_VAL_BIT]
      |=> !LINK_LED_PIN_O)
    else $error("forced low value not on pin");

  a_amdix_write: assert property (wr_phy && WB_SEL_I[1] |=>
      s_q.phy[PHY_AMDIX_BIT] == $past(WB_DAT_I[15]))
    else $error("auto crossover write not taken");

  a_amdix_output: assert property (##1
      AUTO_CROSSOVER_EN_O == $past(s_q.phy[PHY_AMDIX_BIT]))
    else $error("auto crossover output does not follow bit");

  a_cross_write: assert property (wr_phy && WB_SEL_I[1] |=>
      s_q.phy[PHY_CROSS_BIT] == $past(WB_DAT_I[14]))
    else $error("forced crossover write not taken");

  a_pause_rx_only: assert property (HCD_FULL_DUPLEX_I && LOCAL_ADVERT_I == 2'h3
      && PARTNER_ABILITY_I == 2'h2 |=> s_q.pause_rx && !s_q.pause_tx)
    else $error("receive-only pause not resolved");

  a_pause_none: assert property (HCD_FULL_DUPLEX_I && LOCAL_ADVERT_I == 2'h0
      |=> !s_q.pause_rx && !s_q.pause_tx)
    else $error("pause set without local advertisement");

  a_bypass_write: assert property (wr_phy && WB_SEL_I[0] |=>
      s_q.phy[PHY_BYPASS_BIT] == $past(WB_DAT_I[7]))
    else $error("bypass write not taken");

  a_addr_capture: assert property (!s_q.strap_done && s_q.strap_cnt == STRAP_CAPTURE_CNT
      |=> s_q.phy_addr == $past(s_q.strap_s2.phy_addr))
    else $error("PHY address not latched from straps");

  c_blink_toggle: cover property (s_q.blink_phase);
  c_forced_mode: cover property (s_q.led[LED_DRIVE_BIT] && LINK_LED_PIN_O);
  c_pause_both: cover property (s_q.pause_rx && s_q.pause_tx);
  c_phy_write: cover property (wr_phy);
  c_rate_change: cover property ($changed(s_q.led[LED_RATE_HI:LED_RATE_LO]));

endmodule

`default_nettype wire

// *** lpcr_regs_tb.sv ***
// Purpose: self-checking bench for the LED and PHY control register pair
// Assumes: enhanced straps, then common mode straps after a second reset; blink counts 8/16/32/64
// Notes: inputs set by blocking assignment at time 0, then driven by non-blocking assignment after rising edges
`timescale 1ns/1ps
`default_nettype none

module lpcr_regs_tb;
  import lpcr_pkg::*;
  logic ref_clk, rst_b, cyc, stb, we, ack, hcd_fd, link_an, link_up, act_raw, act_str;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, r;
  lpcr_strap_t straps;
  lpcr_pause_adv_t loc_adv, par_adv;
  logic led_pin, auto_x, pair_x;
  int fail_count, compares, n;
  int gaps [4] = '{8, 16, 32, 64};

  lpcr_regs #(.BLINK_CYC_50MS(8), .BLINK_CYC_100MS(16), .BLINK_CYC_200MS(32),
      .BLINK_CYC_500MS(64)) lpcr_regs_i (
    .REF_CLK_I(ref_clk), .RST_B_I(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .STRAPS_I(straps), .LOCAL_ADVERT_I(loc_adv), .PARTNER_ABILITY_I(par_adv),
    .HCD_FULL_DUPLEX_I(hcd_fd), .LINK_100FD_AN_I(link_an), .LINK_UP_I(link_up),
    .ACTIVITY_RAW_I(act_raw), .ACTIVITY_STRETCHED_I(act_str), .LINK_LED_PIN_O(led_pin),
    .AUTO_CROSSOVER_EN_O(auto_x), .PAIR_CROSSOVER_O(pair_x));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("tests done: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      fail_count++;
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d,
      input logic [3:0] s, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= {16'h0000, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    if (k >= 20) chk(32'h0, 32'h1, "no ack");
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
    logic [31:0] q;
    xfer(a, 1'b1, d, s, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    xfer(a, 1'b0, 16'h0000, 4'hF, q);
    chk(q, exp, what);
  endtask

  task automatic pin_chk(input logic exp, input string what);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, led_pin}, {31'h0, exp}, what);
  endtask

  task automatic toggle_gap(output int k);
    logic p;
    p = led_pin;
    k = 0;
    while (led_pin === p && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
  endtask

  function automatic logic [2:0] pause_exp(input logic [4:0] v);
    logic fd, la, lp, pa, pp;
    {fd, la, lp, pa, pp} = v;
    pause_exp = {fd & ((lp & pp) | (lp & la & pa & ~pp)), fd & ((lp & pp) | (~lp & la & pp & pa)),
        v[4] ^ v[0]};
  endfunction

  initial begin
    #2000000;
    $display("[ERR] %0t watchdog timeout", $time);
    fail_count++;
    close_out();
  end

  initial begin
    rst_b = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
    straps = '{common_pin_mode: 1'b0, led_pol: 1'b1, auto_crossover: 1'b0,
        force_crossover: 1'b1, phy_addr: 5'h15};
    loc_adv = '0; par_adv = '0; hcd_fd = 1'b0; link_an = 1'b0; link_up = 1'b1;
    act_raw = 1'b0; act_str = 1'b0;
    fail_count = 0; compares = 0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd_chk(LED_CONTROL_ADR, 32'h0000_0480, "led reset");
    rd_chk(PHY_CONTROL_STATUS_ADR, 32'h0000_4015, "phy reset");
    chk({30'h0, auto_x, pair_x}, 32'h1, "crossover reset");
    $display("test reset values done");

    wr(LED_CONTROL_ADR, 16'hFF7F, 4'h1);
    rd_chk(LED_CONTROL_ADR, 32'h0000_047F, "low byte write");
    wr(LED_CONTROL_ADR, 16'hFFFF);
    rd_chk(LED_CONTROL_ADR, 32'h0000_07FF, "led read-only high bits");
    pin_chk(1'b1, "forced high");
    wr(LED_CONTROL_ADR, 16'h0010);
    pin_chk(1'b0, "forced low");
    wr(LED_CONTROL_ADR, 16'h0000);
    pin_chk(1'b0, "active low link");
    wr(LED_CONTROL_ADR, 16'h0080);
    pin_chk(1'b1, "active high link");
    link_up <= 1'b0;
    pin_chk(1'b0, "active high no link");
    link_up <= 1'b1;
    $display("test led drive done");

    wr(PHY_CONTROL_STATUS_ADR, 16'hFFFF);
    rd_chk(PHY_CONTROL_STATUS_ADR, 32'h0000_C0F5, "phy write ones");
    pin_chk(1'b1, "settle");
    chk({30'h0, auto_x, pair_x}, 32'h3, "crossover on");
    wr(PHY_CONTROL_STATUS_ADR, 16'h0000);
    rd_chk(PHY_CONTROL_STATUS_ADR, 32'h0000_0015, "phy write zeros");
    pin_chk(1'b1, "settle");
    chk({30'h0, auto_x, pair_x}, 32'h0, "crossover off");
    wr(8'h68, 16'hFFFF);
    rd_chk(8'h68, 32'h0, "unmapped read");
    rd_chk(LED_CONTROL_ADR, 32'h0000_0080, "led after unmapped write");
    $display("test phy control done");

    for (int i = 0; i < 32; i++) begin
      @(posedge ref_clk);
      hcd_fd <= i[4]; loc_adv <= i[3:2]; par_adv <= i[1:0]; link_an <= i[4] ^ i[0];
      repeat (2) @(posedge ref_clk);
      xfer(PHY_CONTROL_STATUS_ADR, 1'b0, 16'h0000, 4'hF, r);
      chk({29'h0, r[13:11]}, {29'h0, pause_exp(5'(i))}, "pause and link");
    end
    $display("test pause status done");

    wr(PHY_CONTROL_STATUS_ADR, 16'h0080);
    act_raw <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(LED_CONTROL_ADR, 16'h0080 | (16'(k) << 9));
      // let the reload after a rate change reach the pin first
      repeat (3) @(posedge ref_clk);
      toggle_gap(n);
      toggle_gap(n);
      chk(32'(n), 32'(gaps[k]), "blink half period");
    end
    wr(PHY_CONTROL_STATUS_ADR, 16'h0000);
    repeat (2) @(posedge ref_clk);
    toggle_gap(n);
    chk(32'(n), 32'h0000_00C8, "stretched path steady");
    $display("test blink done");

    // second reset in mid-run with common pin mode straps
    @(posedge ref_clk);
    rst_b <= 1'b0;
    hcd_fd <= 1'b0;
    straps <= '{common_pin_mode: 1'b1, led_pol: 1'b1, auto_crossover: 1'b0,
        force_crossover: 1'b1, phy_addr: 5'h0A};
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd_chk(LED_CONTROL_ADR, 32'h0000_0400, "common led reset");
    rd_chk(PHY_CONTROL_STATUS_ADR, 32'h0000_800A, "common phy reset");
    chk({30'h0, auto_x, pair_x}, 32'h2, "common crossover");
    pin_chk(1'b0, "common active low");
    $display("test common mode reset done");
    close_out();
  end
endmodule

`default_nettype wire
